// file: verilog/wds_supervisor.sv
// Contract
// [RULE1] Out of reset the timer is enabled, 2 s timeout, reset response.
// [RULE2] Clearing the enable bit stops the timer so no expiry action occurs.
// [RULE3] The counter advances on the 32.768 kHz crystal, not the core clock.
// [RULE4] A control write only takes effect right after the unlock step.
// [RULE5] Software unlocks, then writes the register in the next instruction.
// [RULE6] Flash lock bit clear forces response to 0 and enable to 1.
// [RULE7] Under flash lock the timeout select stays writable through unlock.
// [RULE8] The counter is 16 bits; timeout select in bits 7:4 resets to 7.
// [RULE9] Codes 0 to 7 pick periods 15.6 ms doubling up to 2 s.
// [RULE10] Code 8 asks an immediate reset, code 9 a serial-download reset.
// [RULE11] Expiry resets when response bit 3 is 0 and interrupts when it is 1.
// [RULE12] Flag bit 2 sets on timeout; only a 0 write or pin reset clears it.
// [RULE13] Each write setting enable bit 1 enables and clears the counter.
// [RULE14] Bit 0 is the unlock bit and resets to 0.
// [RULE15] The expiry interrupt is high priority; no global mask gates it.
// [RULE16] Unlock lapses after the one instruction following the unlock step.
// [RULE17] Flash lock is sampled as reset ends and held until the next reset.
`timescale 1ns/1ns
`default_nettype none
`include "wds_regs.svh"
module wds_supervisor
    import wds_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock and resets
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_sys_soft_rst,
    // Crystal and flash lock
    input wire logic i_crystal_in,
    input wire logic i_flash_lock_bit,
    // Core register port
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_instr_done,
    output logic [7:0] o_sfr_rdata,
    // Expiry actions
    output logic o_sys_rst_req,
    output logic o_download_rst_req,
    output logic o_expiry_irq
);
    wds_tick_if tick_bus ();

    wds_xtal_tick u_tick (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_crystal_in(i_crystal_in),
        .tick_port(tick_bus.src)
    );

    // [RULE8] select field, wide counter
    logic [3:0] pre;
    logic resp;
    logic flag;
    logic en;
    logic lock;
    logic lock_taken;
    logic [CNT_W-1:0] count;
    wds_unlock_t ul_state;
    logic rst_q;
    logic dl_q;
    logic irq_q;
    logic [7:0] rdata;

    logic [3:0] next_pre;
    logic next_resp;
    logic next_flag;
    logic next_en;
    logic next_lock;
    logic next_lock_taken;
    logic [CNT_W-1:0] next_count;
    wds_unlock_t next_ul_state;
    logic next_rst_q;
    logic next_dl_q;
    logic next_irq_q;
    logic [7:0] next_rdata;

    logic hit;
    logic write_hit;
    logic write_ok;
    logic timed;
    logic expire;
    logic [CNT_W:0] limit_wide;
    logic [CNT_W-1:0] limit;
    logic [7:0] ctrl_value;

    always_comb begin
        hit = (i_sfr_addr == `WDS_CTRL_ADDR);
        write_hit = i_sfr_wr & hit;
        // Only the instruction right after the unlock step may write
        write_ok = write_hit & (ul_state == UL_OPEN);
        timed = (pre <= `WDS_PRE_LAST_TIMED);
        // [RULE9] period from select code
        limit_wide = (CNT_W+1)'(`WDS_BASE_TICKS) << pre[2:0];
        limit = CNT_W'(limit_wide - (CNT_W+1)'(1));
        expire = en & timed & tick_bus.tick & (count == limit);
        // [RULE14] unlock bit reads back
        ctrl_value = {pre, resp, flag, en, ul_state != UL_IDLE};
    end

    always_comb begin
        next_pre = pre;
        next_resp = resp;
        next_flag = flag;
        next_en = en;
        next_lock = lock;
        next_lock_taken = 1'b1;
        next_count = count;
        next_ul_state = ul_state;
        next_rst_q = 1'b0;
        next_dl_q = 1'b0;
        next_irq_q = 1'b0;
        next_rdata = 8'h00;
        // [RULE17] lock sampled once after reset
        if (!lock_taken) begin
            next_lock = i_flash_lock_bit;
        end
        // [RULE16] unlock window closes after one instruction
        if (write_hit && i_sfr_wdata[`WDS_UNLOCK_BIT] && i_instr_done) begin
            next_ul_state = UL_OPEN;
        end else if (write_hit && i_sfr_wdata[`WDS_UNLOCK_BIT]) begin
            next_ul_state = UL_ARMED;
        end else if (write_ok) begin
            next_ul_state = UL_IDLE;
        end else if (i_instr_done) begin
            unique case (ul_state)
                UL_IDLE: next_ul_state = UL_IDLE;
                UL_ARMED: next_ul_state = UL_OPEN;
                UL_OPEN: next_ul_state = UL_IDLE;
            endcase
        end
        // [RULE3] count crystal ticks
        // [RULE2] disabled timer holds still
        if (en && timed && tick_bus.tick) begin
            next_count = expire ? '0 : count + CNT_W'(1);
        end
        // [RULE4] accepted writes only
        if (write_ok) begin
            // [RULE7] select writable even when locked
            next_pre = i_sfr_wdata[`WDS_PRE_HI:`WDS_PRE_LO];
            next_resp = i_sfr_wdata[`WDS_RESP_BIT];
            next_en = i_sfr_wdata[`WDS_EN_BIT];
            if (!i_sfr_wdata[`WDS_FLAG_BIT]) begin
                next_flag = 1'b0;
            end
            // [RULE13] enable write restarts period
            if (i_sfr_wdata[`WDS_EN_BIT]) begin
                next_count = '0;
            end
        end
        // [RULE12] set wins over clear
        if (expire) begin
            next_flag = 1'b1;
        end
        // [RULE11] response selects reset or interrupt
        // [RULE15] no mask stands in front of the interrupt
        next_rst_q = expire & ~resp;
        next_irq_q = expire & resp;
        // [RULE10] immediate reset codes
        if (en && pre == `WDS_PRE_AUTO) begin
            next_rst_q = 1'b1;
        end
        if (en && pre == `WDS_PRE_DL) begin
            next_dl_q = 1'b1;
        end
        if (i_sfr_rd && hit) begin
            next_rdata = ctrl_value;
        end
        // Watchdog-caused reset keeps the flag
        if (i_sys_soft_rst) begin
            next_pre = `WDS_PRE_RST;
            next_resp = `WDS_RESP_RST;
            next_en = `WDS_EN_RST;
            next_count = '0;
            next_ul_state = UL_IDLE;
            next_lock_taken = 1'b0;
            next_rst_q = 1'b0;
            next_dl_q = 1'b0;
            next_irq_q = 1'b0;
        end
        // [RULE6] flash lock pins response and enable
        if (!next_lock) begin
            next_resp = 1'b0;
            next_en = 1'b1;
        end
    end

    // [RULE1] enabled, 2 s, reset response out of reset
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pre <= `WDS_PRE_RST;
            resp <= `WDS_RESP_RST;
            flag <= `WDS_FLAG_RST;
            en <= `WDS_EN_RST;
            lock <= `WDS_LOCK_RST;
            lock_taken <= 1'b0;
            count <= '0;
            ul_state <= UL_IDLE;
            rst_q <= 1'b0;
            dl_q <= 1'b0;
            irq_q <= 1'b0;
            rdata <= 8'h00;
        end else begin
            pre <= next_pre;
            resp <= next_resp;
            flag <= next_flag;
            en <= next_en;
            lock <= next_lock;
            lock_taken <= next_lock_taken;
            count <= next_count;
            ul_state <= next_ul_state;
            rst_q <= next_rst_q;
            dl_q <= next_dl_q;
            irq_q <= next_irq_q;
            rdata <= next_rdata;
        end
    end

    assign o_sfr_rdata = rdata;
    assign o_sys_rst_req = rst_q;
    assign o_download_rst_req = dl_q;
    assign o_expiry_irq = irq_q;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    // [RULE1] reset defaults
    a_reset_defaults: assert property ( // [RULE1]
        $fell(i_sys_rst) |-> en && !resp && pre == `WDS_PRE_RST
    ) else $error("defaults wrong after reset");

    // [RULE2] disabled is quiet
    a_disabled_quiet: assert property ( // [RULE2]
        !en |=> !o_sys_rst_req && !o_expiry_irq && !o_download_rst_req
    ) else $error("action while disabled");

    // [RULE3] tick advances count
    a_tick_advance: assert property ( // [RULE3]
        en && timed && tick_bus.tick && count != limit && !write_ok
            && !i_sys_soft_rst |=> count == $past(count) + CNT_W'(1)
    ) else $error("count did not advance on tick");

    // [RULE4] locked register ignores writes
    a_unlock_needed: assert property ( // [RULE4]
        write_hit && ul_state != UL_OPEN && !i_sys_soft_rst
            |=> $stable(pre)
    ) else $error("write accepted without unlock");

    // [RULE6] flash lock forces fields
    a_flash_forced: assert property ( // [RULE6]
        !lock && lock_taken |-> en && !resp
    ) else $error("lock not forcing fields");

    // [RULE7] select written under unlock
    a_pre_written: assert property ( // [RULE7]
        write_ok && !i_sys_soft_rst
            |=> pre == $past(i_sfr_wdata[`WDS_PRE_HI:`WDS_PRE_LO])
    ) else $error("timeout select not written");

    // [RULE10] immediate auto reset
    a_immediate_rst: assert property ( // [RULE10]
        en && pre == `WDS_PRE_AUTO && !i_sys_soft_rst |=> o_sys_rst_req
    ) else $error("no immediate reset");

    // [RULE10] immediate download reset
    a_download_request: assert property ( // [RULE10]
        en && pre == `WDS_PRE_DL && !i_sys_soft_rst |=> o_download_rst_req
    ) else $error("no download reset");

    // [RULE11] response choice
    a_expiry_resp: assert property ( // [RULE11]
        expire && !i_sys_soft_rst
            |=> o_sys_rst_req == !$past(resp) && o_expiry_irq == $past(resp)
    ) else $error("wrong expiry response");

    // [RULE12] flag follows expiry
    a_expiry_flag: assert property ( // [RULE12]
        expire |=> flag
    ) else $error("flag not set on expiry");

    // [RULE12] flag survives own reset
    a_flag_kept: assert property ( // [RULE12]
        flag && !(write_ok && !i_sfr_wdata[`WDS_FLAG_BIT]) |=> flag
    ) else $error("expiry flag lost");

    // [RULE13] enable write clears count
    a_enable_clear: assert property ( // [RULE13]
        write_ok && i_sfr_wdata[`WDS_EN_BIT] |=> count == '0
    ) else $error("count not cleared on enable write");

    // [RULE16] window lasts one instruction
    a_unlock_lapse: assert property ( // [RULE16]
        ul_state == UL_OPEN && i_instr_done
            && !(write_hit && i_sfr_wdata[`WDS_UNLOCK_BIT])
            |=> ul_state != UL_OPEN
    ) else $error("unlock window outlived instruction");

    // [RULE17] lock held after sampling
    a_lock_stable: assert property ( // [RULE17]
        lock_taken && !i_sys_soft_rst |=> $stable(lock)
    ) else $error("lock changed after sampling");
endmodule
`default_nettype wire

// file: verilog/wds_regs.svh
`ifndef WDS_REGS_SVH
`define WDS_REGS_SVH
// Control register location on the core's register port
`define WDS_CTRL_ADDR 8'hC0
// Field positions
`define WDS_PRE_HI 7
`define WDS_PRE_LO 4
`define WDS_RESP_BIT 3
`define WDS_FLAG_BIT 2
`define WDS_EN_BIT 1
`define WDS_UNLOCK_BIT 0
// Reset values
`define WDS_PRE_RST 4'h7
`define WDS_RESP_RST 1'b0
`define WDS_FLAG_RST 1'b0
`define WDS_EN_RST 1'b1
`define WDS_LOCK_RST 1'b1
// Special timeout codes
`define WDS_PRE_LAST_TIMED 4'h7
`define WDS_PRE_AUTO 4'h8
`define WDS_PRE_DL 4'h9
// Crystal rate and shortest period
`define WDS_XTAL_HZ 32768
`define WDS_BASE_PERIOD_US 15625
`define WDS_BASE_TICKS ((`WDS_XTAL_HZ * `WDS_BASE_PERIOD_US) / 1000000)
`endif

// file: verilog/wds_pkg.sv
package wds_pkg;
    typedef enum logic [2:0] {
        UL_IDLE = 3'b001,
        UL_ARMED = 3'b010,
        UL_OPEN = 3'b100
    } wds_unlock_t;
endpackage

// file: verilog/wds_tick_if.sv
`timescale 1ns/1ns
`default_nettype none
interface wds_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface
`default_nettype wire

// file: verilog/wds_xtal_tick.sv
`timescale 1ns/1ns
`default_nettype none
module wds_xtal_tick (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Crystal level, sampled on i_clk
    input wire logic i_crystal_in,
    // One-cycle tick per crystal rising edge
    wds_tick_if.src tick_port
);
    logic prev;
    logic tick_q;
    logic next_prev;
    logic next_tick;

    always_comb begin
        next_prev = i_crystal_in;
        next_tick = i_crystal_in & ~prev;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            prev <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            prev <= next_prev;
            tick_q <= next_tick;
        end
    end

    assign tick_port.tick = tick_q;
endmodule
`default_nettype wire

// file: verif/wds_supervisor_test.sv
`timescale 1ns/1ns
`default_nettype none
module wds_supervisor_test;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_sys_soft_rst = 1'b0;
    logic i_crystal_in = 1'b0;
    logic i_flash_lock_bit = 1'b1;
    logic [7:0] i_sfr_addr = 8'h00;
    logic i_sfr_wr = 1'b0;
    logic i_sfr_rd = 1'b0;
    logic [7:0] i_sfr_wdata = 8'h00;
    logic i_instr_done = 1'b0;
    logic [7:0] o_sfr_rdata;
    logic o_sys_rst_req;
    logic o_download_rst_req;
    logic o_expiry_irq;
    logic [2:0] outs;
    logic [2:0] xphase = 3'h0;
    int cyc = 0;
    int n_errors = 0;
    int n_tests = 0;
    int n;

    wds_supervisor wds_supervisor_inst (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_sys_soft_rst(i_sys_soft_rst),
        .i_crystal_in(i_crystal_in),
        .i_flash_lock_bit(i_flash_lock_bit),
        .i_sfr_addr(i_sfr_addr),
        .i_sfr_wr(i_sfr_wr),
        .i_sfr_rd(i_sfr_rd),
        .i_sfr_wdata(i_sfr_wdata),
        .i_instr_done(i_instr_done),
        .o_sfr_rdata(o_sfr_rdata),
        .o_sys_rst_req(o_sys_rst_req),
        .o_download_rst_req(o_download_rst_req),
        .o_expiry_irq(o_expiry_irq)
    );

    assign outs = {o_expiry_irq, o_download_rst_req, o_sys_rst_req};

    always #50 i_clk = ~i_clk;

    // Crystal sped up to 8 cycles a period, keeps run short
    always @(posedge i_clk) begin
        xphase <= xphase + 3'h1;
        i_crystal_in <= xphase[2];
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors = n_errors + 1;
            print_verdict();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            n_errors = n_errors + 1;
        end
    endtask

    task automatic chk_n(input string what, input int lo, input int hi);
        n_tests = n_tests + 1;
        if (n < lo || n > hi) begin
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, n);
            n_errors = n_errors + 1;
        end
    endtask

    // One call is one core instruction
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_sfr_addr <= a;
        i_sfr_wdata <= d;
        i_sfr_wr <= 1'b1;
        i_instr_done <= 1'b1;
        @(posedge i_clk);
        i_sfr_wr <= 1'b0;
        i_instr_done <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_sfr_addr <= a;
        i_sfr_rd <= 1'b1;
        @(posedge i_clk);
        i_sfr_rd <= 1'b0;
        @(negedge i_clk);
        chk("rdata", exp, o_sfr_rdata);
    endtask

    task automatic ctl(input logic [7:0] d);
        wr_reg(8'hC0, 8'h01);
        wr_reg(8'hC0, d);
    endtask

    task automatic wait_hi(input int sel, input int lim);
        n = 0;
        while (n < lim && outs[sel] !== 1'b1) begin
            @(negedge i_clk);
            n = n + 1;
        end
    endtask

    task automatic soft_rst();
        @(posedge i_clk);
        i_sys_soft_rst <= 1'b1;
        @(posedge i_clk);
        i_sys_soft_rst <= 1'b0;
    endtask

    task automatic endt(input string s);
        $display("test %s finished", s);
    endtask

    initial begin
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd_chk(8'hC0, 8'h72);
        rd_chk(8'h55, 8'h00);
        wr_reg(8'hC0, 8'h00);
        rd_chk(8'hC0, 8'h72);
        wr_reg(8'hC0, 8'h01);
        rd_chk(8'hC0, 8'h73);
        wr_reg(8'h80, 8'h00);
        wr_reg(8'hC0, 8'h00);
        rd_chk(8'hC0, 8'h72);
        endt("reset_and_unlock");
        ctl(8'h02);
        wait_hi(0, 6000);
        chk_n("rst_pre0", 4080, 4112);
        rd_chk(8'hC0, 8'h06);
        soft_rst();
        rd_chk(8'hC0, 8'h76);
        endt("reset_expiry");
        ctl(8'h1A);
        wait_hi(2, 10000);
        chk_n("irq_pre1", 8176, 8208);
        rd_chk(8'hC0, 8'h1E);
        ctl(8'h18);
        rd_chk(8'hC0, 8'h18);
        wait_hi(2, 9000);
        chk_n("irq_off", 9000, 9000);
        endt("irq_and_disable");
        ctl(8'h82);
        wait_hi(0, 10);
        chk_n("auto_rst", 0, 4);
        ctl(8'h92);
        wait_hi(1, 10);
        chk_n("dl_rst", 0, 4);
        soft_rst();
        rd_chk(8'hC0, 8'h72);
        endt("immediate_codes");
        ctl(8'h0A);
        wait_hi(2, 6000);
        chk_n("irq_pre0", 4080, 4112);
        rd_chk(8'hC0, 8'h0E);
        // Lock takes effect through a fresh pin or soft reset; a pin reset is used here
        @(posedge i_clk);
        i_flash_lock_bit <= 1'b0;
        i_sys_rst <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (2) @(posedge i_clk);
        ctl(8'h38);
        rd_chk(8'hC0, 8'h32);
        // Pin moves after sampling, lock must hold
        @(posedge i_clk);
        i_flash_lock_bit <= 1'b1;
        ctl(8'h38);
        rd_chk(8'hC0, 8'h32);
        endt("flash_lock");
        print_verdict();
    end
endmodule
`default_nettype wire
